// ==== common/swd_prog_defs.svh ====
// timing counts, link constants and key values for the serial debug programmer
`ifndef SWD_PROG_DEFS_SVH
`define SWD_PROG_DEFS_SVH

// ----------------------------------------------------------------
// clock and link rate
// ----------------------------------------------------------------
`define CLK_PERIOD_NS         8
`define SWDCK_MAX_KHZ         8000
`define ENTRY_CLOCK_RATE_KHZ  1400
`define SWD_HALF_CYC          (((1000000 / `SWDCK_MAX_KHZ) + 2 * `CLK_PERIOD_NS - 1) / (2 * `CLK_PERIOD_NS))

// ----------------------------------------------------------------
// entry timing
// ----------------------------------------------------------------
`define RESET_PULSE_NS        1000
`define RESET_PULSE_CYC       ((`RESET_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CLOCK_START_DEADLINE_NS 4000
`define CLOCK_START_CYC       (`CLOCK_START_DEADLINE_NS / `CLK_PERIOD_NS)
`define ENTRY_WINDOW_MIN_US   395
`define ENTRY_WINDOW_MAX_US   430
`define ENTRY_WINDOW_CYC      ((`ENTRY_WINDOW_MIN_US * 1000) / `CLK_PERIOD_NS)
`define SWITCH_WAIT_NS        15000
`define SWITCH_WAIT_CYC       ((`SWITCH_WAIT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define ENTRY_RETRIES         2'd3

// ----------------------------------------------------------------
// packet fields and keys
// ----------------------------------------------------------------
`define ACK_OK                3'b001
`define A_IDCODE              2'b00
`define A_TAR                 2'b01
`define A_DRW                 2'b11
`define ACQUIRE_KEY           32'h7b0c06db
`define TEST_KEY_ADDR         32'h40050210
`define TEST_KEY              32'hea7e30a9
`define SWITCH_KEY            16'he79e
`define SWITCH_ONES_END       8'd56
`define SWITCH_KEY_END        8'd72
`define SWITCH_TAIL_END       8'd128
`define SWITCH_LEN            8'd132

`endif

// ==== common/swd_prog_pkg.sv ====
// state and phase types of the serial debug programmer
package swd_prog_pkg;

	typedef enum logic [3:0] {
		S_IDLE, S_RESET, S_ACQ, S_TKADDR, S_TKDATA, S_WAIT15, S_SWITCH,
		S_IDREAD, S_READY, S_VTAR, S_VDRW, S_VBUF, S_PASS, S_FAIL
	} seq_state_t;

	typedef enum logic [3:0] {
		PH_IDLE, PH_HDR, PH_TRN1, PH_ACK, PH_TRN2, PH_WDATA, PH_RDATA,
		PH_TRN3, PH_TAIL, PH_RAW
	} phase_t;

endpackage : swd_prog_pkg

// ==== logic/swd_prog_host.sv ====
// host programmer: reset, port acquire, test mode entry, id check and byte verify
`timescale 1ns/1ps
`include "swd_prog_defs.svh"

module swd_prog_host #(
	parameter int unsigned ENTRY_WINDOW_CYC = `ENTRY_WINDOW_CYC,
	parameter logic [31:0] EXPECTED_IDCODE  = 32'h0badc0de  // value arbitrary
) (
	input  wire logic        clk,
	input  wire logic        rst_b,
	input  wire logic        start,
	input  wire logic        verify_en,
	input  wire logic        prog_done,
	input  wire logic [31:0] verify_base,
	input  wire logic [15:0] verify_len,
	input  wire logic [7:0]  exp_byte,
	output logic      [15:0] exp_idx,
	output logic             busy,
	output logic             entered,
	output logic             pass,
	output logic             fail,
	output logic             xres_b,
	output logic             swdck,
	input  wire logic        swdio_i,
	output logic             swdio_o,
	output logic             swdio_oe
);
	import swd_prog_pkg::*;

	localparam logic [3:0]  HALF_M1   = 4'(`SWD_HALF_CYC - 1);
	localparam logic [10:0] RESET_M1  = 11'(`RESET_PULSE_CYC - 1);
	localparam logic [10:0] WAIT_M1   = 11'(`SWITCH_WAIT_CYC - 1);
	localparam int          START_MAX = `CLOCK_START_CYC;
	localparam logic [15:0] SW_KEY    = `SWITCH_KEY;

	seq_state_t  state_q, state_d;
	phase_t      ph_q, ph_d;
	logic [10:0] tmr_q, tmr_d;
	logic [15:0] elapsed_q;
	logic [1:0]  retry_q, retry_d;
	logic [15:0] idx_q, idx_d;
	logic        entered_q;
	logic        xres_b_q;
	logic [3:0]  div_q;
	logic        swdck_q;
	logic [7:0]  cnt_q, cnt_d;
	logic        swdio_o_q, swdio_oe_q;
	logic        sdi_m, sdi_q;
	logic [2:0]  ack_q;
	logic [31:0] rd_q;
	logic        rpar_q;
	logic [7:0]  low_cnt_q;

	// ----------------------------------------------------------------
	// pin synchroniser
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sdi_m <= 1'b0;
			sdi_q <= 1'b0;
		end else begin
			sdi_m <= swdio_i;
			sdi_q <= sdi_m;
		end
	end

	// ----------------------------------------------------------------
	// link clock divider
	// ----------------------------------------------------------------
	// 8 cycles a half gives 7.8 MHz: under the 8 MHz ceiling, well over 1.4 MHz
	wire clk_run = (state_q != S_IDLE) && (state_q != S_RESET);
	wire div_end = (div_q == HALF_M1);
	wire fall    = clk_run && swdck_q && div_end;

	always_ff @(posedge clk) begin
		if (!rst_b || !clk_run) begin
			div_q   <= 4'h0;
			swdck_q <= 1'b0;
		end else begin
			div_q   <= div_end ? 4'h0 : div_q + 4'h1;
			swdck_q <= div_end ? !swdck_q : swdck_q;
		end
	end

	// ----------------------------------------------------------------
	// transaction selection by sequence state
	// ----------------------------------------------------------------
	wire [31:0] vaddr     = verify_base + {16'h0000, idx_q};
	wire        apndp_sel = (state_q == S_TKADDR) || (state_q == S_TKDATA)
	                     || (state_q == S_VTAR) || (state_q == S_VDRW);
	wire        rnw_sel   = (state_q == S_IDREAD) || (state_q == S_VDRW) || (state_q == S_VBUF);
	wire        raw_sel   = (state_q == S_SWITCH);
	wire [1:0]  a_sel     = ((state_q == S_TKADDR) || (state_q == S_VTAR)) ? `A_TAR :
	                        (state_q == S_IDREAD) ? `A_IDCODE : `A_DRW;
	wire [31:0] wd_sel    = (state_q == S_ACQ) ? `ACQUIRE_KEY :
	                        (state_q == S_TKADDR) ? `TEST_KEY_ADDR :
	                        (state_q == S_TKDATA) ? `TEST_KEY : {vaddr[31:2], 2'b00};
	wire        txn_state = (state_q == S_ACQ) || (state_q == S_TKADDR)
	                     || (state_q == S_TKDATA) || raw_sel || (state_q == S_IDREAD)
	                     || (state_q == S_VTAR) || (state_q == S_VDRW) || (state_q == S_VBUF);
	wire        xfer_go   = txn_state && (ph_q == PH_IDLE);
	wire [7:0]  hdr_w     = {1'b1, 1'b0, ^{a_sel, rnw_sel, apndp_sel}, a_sel[1], a_sel[0],
	                         rnw_sel, apndp_sel, 1'b1};

	// ----------------------------------------------------------------
	// bit engine, one slot per link clock period
	// ----------------------------------------------------------------
	function automatic logic [7:0] ph_len(input phase_t p);
		case (p)
			PH_HDR:   ph_len = 8'd8;
			PH_ACK:   ph_len = 8'd3;
			PH_WDATA: ph_len = 8'd33;
			PH_RDATA: ph_len = 8'd33;
			PH_TAIL:  ph_len = 8'd2;
			PH_RAW:   ph_len = `SWITCH_LEN;
			default:  ph_len = 8'd1;
		endcase
	endfunction : ph_len

	wire       last   = (cnt_q == ph_len(ph_q) - 8'd1);
	wire [2:0] ack_now = {sdi_q, ack_q[1:0]};

	always_comb begin
		ph_d  = ph_q;
		cnt_d = last ? 8'd0 : cnt_q + 8'd1;
		case (ph_q)
			PH_IDLE: begin
				cnt_d = 8'd0;
				if (xfer_go) ph_d = raw_sel ? PH_RAW : PH_HDR;
			end
			PH_HDR:   if (last) ph_d = PH_TRN1;
			PH_TRN1:  ph_d = PH_ACK;
			PH_ACK:   if (last) ph_d = (ack_now != `ACK_OK) ? PH_TRN3 :
			                           rnw_sel ? PH_RDATA : PH_TRN2;
			PH_TRN2:  ph_d = PH_WDATA;
			PH_WDATA: if (last) ph_d = PH_TAIL;
			PH_RDATA: if (last) ph_d = PH_TRN3;
			PH_TRN3:  ph_d = PH_TAIL;
			PH_TAIL:  if (last) ph_d = PH_IDLE;
			PH_RAW:   if (last) ph_d = PH_IDLE;
			default:  ph_d = PH_IDLE;
		endcase
	end

	wire [3:0] key_i   = 4'(cnt_d - `SWITCH_ONES_END);
	wire       raw_bit = (cnt_d < `SWITCH_ONES_END) ? 1'b1 :
	                     (cnt_d < `SWITCH_KEY_END) ? SW_KEY[key_i] :
	                     (cnt_d < `SWITCH_TAIL_END);
	wire       drive_d = (ph_d == PH_IDLE) || (ph_d == PH_HDR) || (ph_d == PH_WDATA)
	                  || (ph_d == PH_TAIL) || (ph_d == PH_RAW);
	wire       bit_d   = (ph_d == PH_HDR) ? hdr_w[cnt_d[2:0]] :
	                     (ph_d == PH_WDATA) ? (cnt_d[5] ? ^wd_sel : wd_sel[cnt_d[4:0]]) :
	                     (ph_d == PH_RAW) ? raw_bit : 1'b0;

	// switch sequence mode-select bits move on the falling edge like all other bits
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ph_q       <= PH_IDLE;
			cnt_q      <= 8'd0;
			swdio_o_q  <= 1'b0;
			swdio_oe_q <= 1'b1;
		end else if (fall) begin
			ph_q       <= ph_d;
			cnt_q      <= cnt_d;
			swdio_o_q  <= bit_d;
			swdio_oe_q <= drive_d;
		end
	end

	// target launched mid-slot on the rising edge; sampled at the closing fall
	// no data returns during the switch, so nothing is sampled at the fall
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			ack_q  <= 3'b000;
			rd_q   <= 32'h0000_0000;
			rpar_q <= 1'b0;
		end else if (fall && ph_q == PH_ACK) begin
			ack_q[cnt_q[1:0]] <= sdi_q;
		end else if (fall && ph_q == PH_RDATA) begin
			if (cnt_q[5]) rpar_q <= sdi_q;
			else rd_q[cnt_q[4:0]] <= sdi_q;
		end
	end

	wire xfer_done = fall && last && ((ph_q == PH_TAIL) || (ph_q == PH_RAW));
	wire xfer_ok   = (ack_q == `ACK_OK) && (!rnw_sel || ((^rd_q) == rpar_q));
	wire [7:0] rd_byte = rd_q[{vaddr[1:0], 3'b000} +: 8];

	// ----------------------------------------------------------------
	// entry and verify sequencer
	// ----------------------------------------------------------------
	wire        late      = (elapsed_q >= 16'(ENTRY_WINDOW_CYC));
	wire        verify_ok = verify_en && prog_done && (verify_len != 16'h0000);
	seq_state_t retry_st;
	assign retry_st = (retry_q == `ENTRY_RETRIES) ? S_FAIL : S_RESET;

	always_comb begin
		state_d = state_q;
		retry_d = retry_q;
		idx_d   = idx_q;
		case (state_q)
			S_IDLE: if (start) begin
				state_d = S_RESET;
				retry_d = 2'd0;
			end
			S_RESET:  if (tmr_q == RESET_M1) state_d = S_ACQ;
			S_ACQ: if (xfer_done) begin
				if (xfer_ok && !late) state_d = S_TKADDR;
				else if (late) state_d = retry_st;
			end
			S_TKADDR: if (xfer_done) state_d = (xfer_ok && !late) ? S_TKDATA : retry_st;
			S_TKDATA: if (xfer_done) state_d = (xfer_ok && !late) ? S_WAIT15 : retry_st;
			S_WAIT15: if (tmr_q == WAIT_M1) state_d = S_SWITCH;
			S_SWITCH: if (xfer_done) state_d = S_IDREAD;
			S_IDREAD: if (xfer_done) begin
				state_d = (xfer_ok && rd_q == EXPECTED_IDCODE) ? S_READY : S_FAIL;
			end
			S_READY: begin
				idx_d   = 16'h0000;
				state_d = verify_ok ? S_VTAR : S_PASS;
			end
			S_VTAR: if (xfer_done) state_d = xfer_ok ? S_VDRW : S_FAIL;
			S_VDRW: if (xfer_done) state_d = xfer_ok ? S_VBUF : S_FAIL;
			S_VBUF: if (xfer_done) begin
				if (!xfer_ok || rd_byte != exp_byte) state_d = S_FAIL;
				else if (idx_q == verify_len - 16'h0001) state_d = S_PASS;
				else begin
					state_d = S_VTAR;
					idx_d   = idx_q + 16'h0001;
				end
			end
			S_PASS, S_FAIL: if (start) begin
				state_d = S_RESET;
				retry_d = 2'd0;
			end
			default: state_d = S_IDLE;
		endcase
		if (state_d == S_RESET && state_q != S_IDLE && !start) retry_d = retry_q + 2'd1;
		tmr_d = (state_d != state_q) ? 11'd0 : tmr_q + 11'd1;
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_q   <= S_IDLE;
			tmr_q     <= 11'd0;
			retry_q   <= 2'd0;
			idx_q     <= 16'h0000;
			xres_b_q  <= 1'b1;
			entered_q <= 1'b0;
		end else begin
			state_q   <= state_d;
			tmr_q     <= tmr_d;
			retry_q   <= retry_d;
			idx_q     <= idx_d;
			xres_b_q  <= (state_d != S_RESET);
			entered_q <= (state_d == S_RESET) ? 1'b0 : entered_q || (state_d == S_READY);
		end
	end

	// counts from reset release; 16 bits cover 430 us at 8 ns
	always_ff @(posedge clk) begin
		if (!rst_b || state_q == S_RESET) elapsed_q <= 16'h0000;
		else if (elapsed_q != 16'hffff) elapsed_q <= elapsed_q + 16'h0001;
	end

	assign exp_idx  = idx_q;
	assign busy     = (state_q != S_IDLE) && (state_q != S_PASS) && (state_q != S_FAIL);
	assign entered  = entered_q;
	assign pass     = (state_q == S_PASS);
	assign fail     = (state_q == S_FAIL);
	assign xres_b   = xres_b_q;
	assign swdck    = swdck_q;
	assign swdio_o  = swdio_o_q;
	assign swdio_oe = swdio_oe_q;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (!rst_b || xres_b_q) low_cnt_q <= 8'd0;
		else if (low_cnt_q != 8'hff) low_cnt_q <= low_cnt_q + 8'd1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_reset_width: assert property ($rose(xres_b_q) |-> $past(low_cnt_q) >= 8'd124)
		else $error("target reset low too short");
	chk_clock_start: assert property ($rose(xres_b_q) |-> ##[1:START_MAX] $rose(swdck_q))
		else $error("link clock late after reset release");
	// a restart from pass or fail may cut the high phase short on purpose
	chk_clock_high: assert property ($rose(swdck_q) |-> (swdck_q || state_q == S_RESET)[*8])
		else $error("link clock high phase too short");
	chk_clock_low: assert property ($fell(swdck_q) && clk_run |-> !swdck_q[*8])
		else $error("link clock low phase too short");
	chk_drive_fall: assert property (($changed(swdio_o_q) || $changed(swdio_oe_q)) |-> $fell(swdck_q))
		else $error("data line changed off the falling edge");
	chk_entry_window: assert property ($rose(state_q == S_WAIT15) |-> $past(elapsed_q) < 16'(ENTRY_WINDOW_CYC))
		else $error("test mode entry outside window");
	chk_switch_wait: assert property ($rose(state_q == S_SWITCH) |-> $past(tmr_q) == WAIT_M1)
		else $error("switch sequence before 15 us wait");
	chk_acquire_retry: assert property (state_q == S_ACQ && xfer_done && !xfer_ok && !late |=> state_q == S_ACQ ##[1:20] ph_q == PH_HDR)
		else $error("acquire key not repeated");
	chk_verify_gate: assert property ($rose(state_q == S_VTAR) && $past(state_q) == S_READY |-> $past(verify_ok))
		else $error("verify started without programming");
	chk_byte_mismatch: assert property (state_q == S_VBUF && xfer_done && xfer_ok && rd_byte != exp_byte |=> fail)
		else $error("byte mismatch did not fail");

	cov_entered: cover property ($rose(entered_q));
	cov_pass: cover property ($rose(state_q == S_PASS) && $past(state_q) == S_VBUF);
	cov_acq_retry: cover property (state_q == S_ACQ && xfer_done && !xfer_ok);
	cov_fail: cover property ($rose(state_q == S_FAIL));

endmodule : swd_prog_host

// ==== bench/swd_target_model.sv ====
// behavioural serial debug target answering the programmer
`timescale 1ns/1ps
`include "swd_prog_defs.svh"

module swd_target_model #(
	parameter logic [31:0] ID_VALUE = 32'h0badc0de, // value arbitrary
	parameter int          ACQ_NS   = 9000,
	parameter int          BOOT_NS  = 68000,
	parameter int          TM_NS    = 430000
) (
	input  wire logic       xres_b,
	input  wire logic       swdck,
	input  wire logic       swdio,
	input  wire logic [1:0] fault_mode,
	output logic            tgt_o,
	output logic            tgt_oe
);
	logic [7:0]  hdr;
	logic [31:0] sh, tar, rdbuf, rword;
	logic [2:0]  ack;
	logic [1:0]  a;
	logic        acq, sync_ok, seen_lr, ap, rd;
	int          cnt, ones, zeros;
	realtime     rel, t;

	function automatic logic [31:0] word_at(input logic [31:0] w);
		logic [7:0] b;
		b = w[7:0] & 8'hfc;
		return {b + 8'h03, b + 8'h02, b + 8'h01, b} ^ 32'h5a5a5a5a;
	endfunction : word_at

	initial begin
		tgt_o = 1'b0;
		tgt_oe = 1'b0;
		tar = '0;
		rdbuf = '0;
		rel = 0;
		ones = 0;
		zeros = 0;
	end

	always @(negedge xres_b) begin
		cnt = -1;
		acq = 1'b0;
		sync_ok = 1'b1;
		seen_lr = 1'b0;
		tgt_oe = 1'b0;
	end

	always @(posedge xres_b) rel = $realtime;

	// ----------------------------------------------------------------
	// link slots, all taken and launched on the clock rise
	// ----------------------------------------------------------------
	// the switch sequence is taken on the rise, as mode-select bits would be
	always @(posedge swdck) begin
		if (xres_b) begin
			tgt_oe = 1'b0;
			// released line shows the inverse of the last level
			tgt_o = ~swdio;
			if (cnt < 0) begin
				ones = swdio ? ones + 1 : 0;
				seen_lr = seen_lr | (ones >= 50);
				// after test mode a header only follows a line reset
				if (swdio && (sync_ok || (seen_lr && zeros >= 3))) begin
					cnt = 0;
					sync_ok = 1'b1;
					seen_lr = 1'b0;
				end
				zeros = swdio ? 0 : zeros + 1;
			end else begin
				cnt = cnt + 1;
				if (cnt < 8) hdr[cnt] = swdio;
				if (cnt == 8) begin
					ap = hdr[1];
					rd = hdr[2];
					a = hdr[4:3];
					t = $realtime - rel;
					ack = `ACK_OK;
					if (rd && !ap && a == `A_IDCODE && t < BOOT_NS) ack = 3'b010;
					if (!rd && ap && a == `A_DRW && t > TM_NS) ack = 3'b100;
					if ((!acq && t > ACQ_NS) || fault_mode == 2'd1) ack = 3'b000;
					rword = (ap || a != `A_IDCODE) ? rdbuf : ID_VALUE ^ {31'h0, fault_mode == 2'd2};
					if (rd && ap && a == `A_DRW) rdbuf = word_at(tar);
				end
				if (cnt >= 9 && cnt <= 11 && ack != 3'b000) begin
					tgt_oe = 1'b1;
					tgt_o = ack[cnt - 9];
				end
				if (cnt == 12 && ack != `ACK_OK) cnt = -1;
				else if (rd && cnt >= 12 && cnt <= 44) begin
					tgt_oe = 1'b1;
					tgt_o = (cnt == 44) ? ^rword : rword[cnt - 12];
				end else if (!rd && cnt >= 13 && cnt <= 44) sh[cnt - 13] = swdio;
				if (cnt == 45) begin
					if (!rd && !ap && a == `A_DRW && sh == `ACQUIRE_KEY) acq = 1'b1;
					if (!rd && ap && a == `A_TAR) tar = sh;
					if (!rd && ap && a == `A_DRW && tar == `TEST_KEY_ADDR && sh == `TEST_KEY)
						sync_ok = 1'b0;
					cnt = -1;
				end
			end
		end
	end
endmodule : swd_target_model

// ==== bench/test_swd_prog_host.sv ====
// self-checking bench for the serial debug programmer
`timescale 1ns/1ps
`include "swd_prog_defs.svh"

module test_swd_prog_host;
	import swd_prog_pkg::*;

	typedef struct {
		logic p;
		logic e;
		int   res;
		int   base;
	} note_t;

	localparam int unsigned WIN_CYC = 4000;
	localparam logic [31:0] ID_VAL  = 32'h1d5e7a01; // value arbitrary

	logic        clk, rst_b, start, verify_en, prog_done, bad_all;
	logic [31:0] verify_base, cur_addr;
	logic [15:0] verify_len, exp_idx, bad_idx, len_r;
	logic [7:0]  exp_byte;
	logic [1:0]  fault_mode;
	logic        busy, entered, pass, fail, xres_b, swdck, swdio_o, swdio_oe;
	logic        tgt_o, tgt_oe, swdio_w, prev_ck, prev_o, prev_oe, prev_x, prev_r, prev_d;
	int          error_cnt, num_checks, cyc, resets, lowcnt, since_rel, period;
	logic        started, have_prev;
	note_t       q[$];
	note_t       n;

	assign swdio_w = swdio_oe ? swdio_o : tgt_o;
	assign cur_addr = verify_base + {16'h0000, exp_idx};
	assign exp_byte = cur_addr[7:0] ^ 8'h5a ^ {7'h00, bad_all || exp_idx == bad_idx};

	swd_prog_host #(.ENTRY_WINDOW_CYC(WIN_CYC), .EXPECTED_IDCODE(ID_VAL)) u_swd_prog_host (
		.clk(clk), .rst_b(rst_b), .start(start), .verify_en(verify_en),
		.prog_done(prog_done), .verify_base(verify_base), .verify_len(verify_len),
		.exp_byte(exp_byte), .exp_idx(exp_idx), .busy(busy), .entered(entered),
		.pass(pass), .fail(fail), .xres_b(xres_b), .swdck(swdck), .swdio_i(swdio_w),
		.swdio_o(swdio_o), .swdio_oe(swdio_oe));

	swd_target_model #(.ID_VALUE(ID_VAL), .BOOT_NS(30000)) u_swd_target_model (
		.xres_b(xres_b), .swdck(swdck), .swdio(swdio_w), .fault_mode(fault_mode),
		.tgt_o(tgt_o), .tgt_oe(tgt_oe));

	task automatic check(input logic ok, input string msg);
		num_checks = num_checks + 1;
		if (ok !== 1'b1) begin
			error_cnt = error_cnt + 1;
			$display("ERROR at %0t: %s", $time, msg);
		end
	endtask : check

	task automatic end_of_test();
		$display("checks %0d, mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : end_of_test

	// ----------------------------------------------------------------
	// watchers
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc = cyc + 1;
		if (cyc == 90000) begin
			error_cnt = error_cnt + 1;
			$display("ERROR at %0t: run hung", $time);
			end_of_test();
		end
		if (rst_b === 1'b1 && prev_r === 1'b1) begin
			if (swdio_o !== prev_o || swdio_oe !== prev_oe)
				check(prev_ck === 1'b1 && swdck === 1'b0, "data moved off clock fall");
			if (swdio_oe === 1'b1 && tgt_oe === 1'b1) check(1'b0, "both ends drive data");
			period = period + 1;
			since_rel = since_rel + 1;
			lowcnt = lowcnt + 1;
			if (xres_b === 1'b0 && prev_x === 1'b1) begin
				resets = resets + 1;
				started = 1'b0;
				have_prev = 1'b0;
				lowcnt = 1;
			end
			if (xres_b === 1'b1 && prev_x === 1'b0) begin
				check(lowcnt - 1 >= `RESET_PULSE_CYC, "target reset too short");
				since_rel = 0;
			end
			if (swdck === 1'b1 && prev_ck === 1'b0) begin
				if (!started) check(since_rel <= `CLOCK_START_CYC, "clock started late");
				if (have_prev) check(period >= 16 && period <= 89, "link clock rate");
				started = 1'b1;
				have_prev = 1'b1;
				period = 0;
			end
			if ((pass | fail) === 1'b1 && prev_d === 1'b0) begin
				if (q.size() == 0) check(1'b0, "result with no note");
				else begin
					n = q.pop_front();
					check({pass, fail, entered} === {n.p, !n.p, n.e}, "outcome");
					if (n.res >= 0) check(resets - n.base == n.res, "reset count");
				end
			end
		end
		{prev_ck, prev_o, prev_oe, prev_x, prev_r, prev_d} = {swdck, swdio_o, swdio_oe,
			xres_b, rst_b, pass | fail};
	end

	// ----------------------------------------------------------------
	// stimulus
	// ----------------------------------------------------------------
	task automatic run_test(input logic [1:0] fm, input logic pd, input logic en,
			input logic [15:0] len, input logic [15:0] bad, input logic all,
			input logic ep, input logic ee, input int res);
		note_t nt;
		int    i;
		nt.p = ep;
		nt.e = ee;
		nt.res = res;
		nt.base = resets;
		q.push_back(nt);
		fault_mode <= fm;
		prog_done <= pd;
		verify_en <= en;
		verify_len <= len;
		bad_idx <= bad;
		bad_all <= all;
		verify_base <= $urandom;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		for (i = 0; i < 40000; i++) begin
			@(posedge clk);
			if (busy === 1'b0) break;
		end
		$display("test end: pass=%b fail=%b entered=%b", pass, fail, entered);
		repeat (2) @(posedge clk);
	endtask : run_test

	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	initial begin
		{rst_b, start, verify_en, prog_done, bad_all, fault_mode} = '0;
		{verify_base, verify_len, bad_idx} = '0;
		{error_cnt, num_checks, cyc, resets, lowcnt, since_rel, period} = '0;
		{started, have_prev} = 2'b10;
		void'($urandom(5745));
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		@(posedge clk);
		len_r = 16'(1 + $urandom % 2);
		run_test(2'd0, 1'b1, 1'b1, len_r, 16'hffff, 1'b0, 1'b1, 1'b1, 1);
		run_test(2'd0, 1'b1, 1'b1, len_r, 16'($urandom % len_r), 1'b0, 1'b0, 1'b1, -1);
		run_test(2'd0, 1'b0, 1'b1, len_r, 16'hffff, 1'b1, 1'b1, 1'b1, 1);
		run_test(2'd0, 1'b1, 1'b0, len_r, 16'hffff, 1'b1, 1'b1, 1'b1, 1);
		run_test(2'd0, 1'b1, 1'b1, 16'h0000, 16'hffff, 1'b1, 1'b1, 1'b1, 1);
		run_test(2'd2, 1'b1, 1'b1, len_r, 16'hffff, 1'b0, 1'b0, 1'b0, -1);
		run_test(2'd1, 1'b1, 1'b1, len_r, 16'hffff, 1'b0, 1'b0, 1'b0, 4);
		check(q.size() == 0, "results missing");
		end_of_test();
	end
endmodule : test_swd_prog_host
